// *** logic/gif_gpio.sv ***
// gpio unit: edge interrupts, debounce, pull and fade selection, levels
`include "gif_map.svh"
`default_nettype none
module gif_gpio #(
    parameter int unsigned DEB_TICK_CYC = `GIF_DEB_TICK_CYC,
    parameter int unsigned PHASE_CYC = `GIF_PHASE_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire gif_pkg::gif_req_s host_req,
    output logic [7:0] host_rdata,
    input wire logic [7:0] general_input_pin,
    input wire gif_pkg::gif_pincfg_s pin_cfg,
    input wire logic low_power_mode,
    output logic irq_out_n,
    output logic wake_request,
    output logic [7:0] pull_up_en,
    output logic [7:0] pull_down_en,
    output logic [15:0] fade_mode_out,
    output logic [7:0] fading_output_onoff,
    output logic [63:0] direct_output_level
);
    import gif_pkg::*;
    gif_top_s s, next_s;
    logic ms_tick;
    logic phase_tick;
    logic [7:0] lvl;
    logic [7:0] is_in;
    logic [7:0] hit;
    logic [7:0] pu_v;
    logic [7:0] pd_v;
    logic [15:0] fade_v;
    logic [7:0] pwr_val4;
    logic ctrl_wr;
    logic ctrl_rd;

    gif_tick_div #(.CYCLES(DEB_TICK_CYC)) u_ms_div (
        .clock(clock),
        .reset_n(reset_n),
        .tick(ms_tick)
    );
    // phase start is where pending writes become active
    gif_tick_div #(.CYCLES(PHASE_CYC)) u_phase_div (
        .clock(clock),
        .reset_n(reset_n),
        .tick(phase_tick)
    );

    for (genvar i = 0; i < 8; i++) begin : g_pin
        logic [1:0] es;
        logic [1:0] ps;
        gif_fade_e fm;
        assign is_in[i] = pin_cfg.func[i] == GIF_FN_INPUT;
        assign es = s.edge_sel[2*i +: 2];
        assign ps = s.pull[2*i +: 2];
        assign fm = gif_fade_e'(s.fade[2*i +: 2]);
        gif_debounce u_deb (
            .clock(clock),
            .reset_n(reset_n),
            .pin(general_input_pin[i]),
            .sample_tick(ms_tick),
            .enable(s.deb[i] & is_in[i]),
            .level(lvl[i])
        );
        assign hit[i] = is_in[i] & (
            (es == GIF_EDGE_RISE & lvl[i] & ~s.prev[i]) |
            (es == GIF_EDGE_FALL & ~lvl[i] & s.prev[i]) |
            (es == GIF_EDGE_BOTH & (lvl[i] != s.prev[i])));
        assign pu_v[i] = is_in[i] & (ps == 2'h1);
        assign pd_v[i] = is_in[i] & (ps == 2'h2);
        assign fade_v[2*i +: 2] = (pin_cfg.func[i] != GIF_FN_FADE) ? 2'h0 :
            (fm == GIF_FADE_RSVD) ? GIF_FADE_SINGLE : fm;
    end

    assign ctrl_wr = host_req.wr & (host_req.bank == `GIF_BANK_CTRL);
    assign ctrl_rd = host_req.rd & (host_req.bank == `GIF_BANK_CTRL);
    assign pwr_val4 = pin_cfg.pwrup[4] ? pin_cfg.on_lvl[4] :
        pin_cfg.off_lvl[4];

    always_comb begin
        next_s = s;
        next_s.wake = 1'b0;
        next_s.prev = lvl;
        next_s.stat = lvl & is_in;
        next_s.pu = pu_v;
        next_s.pd = pd_v;
        next_s.fade_out = fade_v;
        if (!s.pwr_done) begin
            next_s.pwr_done = 1'b1;
            for (int i = 0; i < 8; i++) begin
                if (pin_cfg.func[i] == GIF_FN_DIRECT) begin
                    next_s.intens[i] = pin_cfg.pwrup[i] ?
                        pin_cfg.on_lvl[i] : pin_cfg.off_lvl[i];
                end
            end
        end
        if (phase_tick) begin
            next_s.pull = s.pend_pull;
            next_s.edge_sel = s.pend_edge;
            next_s.deb = s.pend_deb;
            next_s.fade = s.pend_fade;
            next_s.onoff = s.pend_onoff;
            next_s.pend_lvl_we = 1'b0;
            if (s.pend_lvl_we &&
                pin_cfg.func[s.pend_sel] == GIF_FN_DIRECT) begin
                next_s.intens[s.pend_sel] = s.pend_lvl;
            end
        end
        if (host_req.wr) begin
            case ({host_req.bank, host_req.addr})
                {`GIF_BANK_PULL_EDGE, `GIF_OFS_PULL_HI}:
                    next_s.pend_pull[15:8] = host_req.wdata;
                {`GIF_BANK_PULL_EDGE, `GIF_OFS_PULL_LO}:
                    next_s.pend_pull[7:0] = host_req.wdata;
                {`GIF_BANK_PULL_EDGE, `GIF_OFS_EDGE_HI}:
                    next_s.pend_edge[15:8] = host_req.wdata;
                {`GIF_BANK_PULL_EDGE, `GIF_OFS_EDGE_LO}:
                    next_s.pend_edge[7:0] = host_req.wdata;
                {`GIF_BANK_DEBOUNCE, `GIF_OFS_DEBOUNCE}:
                    next_s.pend_deb = host_req.wdata;
                {`GIF_BANK_FADE, `GIF_OFS_FADE_HI}:
                    next_s.pend_fade[15:8] = host_req.wdata;
                {`GIF_BANK_FADE, `GIF_OFS_FADE_LO}:
                    next_s.pend_fade[7:0] = host_req.wdata;
                {`GIF_BANK_CTRL, `GIF_OFS_ONOFF}:
                    next_s.pend_onoff = (host_req.wdata & ~pin_cfg.auto) |
                        (s.pend_onoff & pin_cfg.auto);
                {`GIF_BANK_CTRL, `GIF_OFS_PIN_SEL}:
                    next_s.pend_sel = host_req.wdata[2:0];
                {`GIF_BANK_CTRL, `GIF_OFS_LEVEL}: begin
                    next_s.pend_lvl = host_req.wdata;
                    next_s.pend_lvl_we = 1'b1;
                end
                default: ;
            endcase
        end
        if (host_req.rd) begin
            case ({host_req.bank, host_req.addr})
                {`GIF_BANK_PULL_EDGE, `GIF_OFS_PULL_HI}:
                    next_s.rdata = s.pend_pull[15:8];
                {`GIF_BANK_PULL_EDGE, `GIF_OFS_PULL_LO}:
                    next_s.rdata = s.pend_pull[7:0];
                {`GIF_BANK_PULL_EDGE, `GIF_OFS_EDGE_HI}:
                    next_s.rdata = s.pend_edge[15:8];
                {`GIF_BANK_PULL_EDGE, `GIF_OFS_EDGE_LO}:
                    next_s.rdata = s.pend_edge[7:0];
                {`GIF_BANK_DEBOUNCE, `GIF_OFS_DEBOUNCE}:
                    next_s.rdata = s.pend_deb;
                {`GIF_BANK_FADE, `GIF_OFS_FADE_HI}:
                    next_s.rdata = s.pend_fade[15:8];
                {`GIF_BANK_FADE, `GIF_OFS_FADE_LO}:
                    next_s.rdata = s.pend_fade[7:0];
                {`GIF_BANK_CTRL, `GIF_OFS_IRQ_SRC}:
                    next_s.rdata = s.irq_src;
                {`GIF_BANK_CTRL, `GIF_OFS_IN_STAT}:
                    next_s.rdata = s.stat;
                {`GIF_BANK_CTRL, `GIF_OFS_ONOFF}:
                    next_s.rdata = s.pend_onoff;
                {`GIF_BANK_CTRL, `GIF_OFS_PIN_SEL}:
                    next_s.rdata = {5'h00, s.pend_sel};
                {`GIF_BANK_CTRL, `GIF_OFS_LEVEL}:
                    next_s.rdata = s.intens[s.pend_sel];
                default:
                    next_s.rdata = 8'h00;
            endcase
        end
        // read clears the source; a new edge in the same cycle wins
        if (ctrl_rd && host_req.addr == `GIF_OFS_IRQ_SRC) begin
            next_s.irq_src = 8'h00;
        end
        if (|hit) begin
            next_s.irq_src[`GIF_IRQ_INPUT_BIT] = 1'b1;
        end
        next_s.irq_n = ~|next_s.irq_src;
        next_s.wake = (|hit) & low_power_mode;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.pend_pull <= `GIF_PULL_RST;
            s.pull <= `GIF_PULL_RST;
            s.pend_edge <= `GIF_EDGE_RST;
            s.edge_sel <= `GIF_EDGE_RST;
            s.pend_deb <= `GIF_DEBOUNCE_RST;
            s.deb <= `GIF_DEBOUNCE_RST;
            s.pend_fade <= `GIF_FADE_RST;
            s.fade <= `GIF_FADE_RST;
            s.irq_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign host_rdata = s.rdata;
    assign irq_out_n = s.irq_n;
    assign wake_request = s.wake;
    assign pull_up_en = s.pu;
    assign pull_down_en = s.pd;
    assign fade_mode_out = s.fade_out;
    assign fading_output_onoff = s.onoff;
    assign direct_output_level = s.intens;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    property p_edge_irq;
        |hit |=> s.irq_src[`GIF_IRQ_INPUT_BIT] ##1 !irq_out_n;
    endproperty
    a_edge_irq: assert property (p_edge_irq)
        else $error("input edge did not raise the interrupt");
    property p_rise_only;
        (is_in[0] && s.edge_sel[1:0] == 2'h1 && !lvl[0] && s.prev[0])
            |-> !hit[0];
    endproperty
    a_rise_only: assert property (p_rise_only)
        else $error("falling edge taken under rising select");
    property p_wake;
        (|hit && low_power_mode) |=> wake_request ##1 !wake_request;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake pulse missing or too long");
    property p_fade_cont;
        (pin_cfg.func[7] == GIF_FN_FADE && s.fade[15:14] == 2'h1)
            |=> fade_mode_out[15:14] == 2'h1;
    endproperty
    a_fade_cont: assert property (p_fade_cont)
        else $error("continuous fade mode not driven");
    property p_fade_rsvd;
        (pin_cfg.func[7] == GIF_FN_FADE && s.fade[15:14] == 2'h3)
            |=> fade_mode_out[15:14] == 2'h0;
    endproperty
    a_fade_rsvd: assert property (p_fade_rsvd)
        else $error("reserved fade code not taken as single");
    property p_pwrup;
        (!s.pwr_done && pin_cfg.func[4] == GIF_FN_DIRECT)
            |=> direct_output_level[39:32] == $past(pwr_val4);
    endproperty
    a_pwrup: assert property (p_pwrup)
        else $error("power-up level not loaded");
    property p_auto_ignore;
        (ctrl_wr && host_req.addr == `GIF_OFS_ONOFF && pin_cfg.auto[6])
            |=> s.pend_onoff[6] == $past(s.pend_onoff[6]);
    endproperty
    a_auto_ignore: assert property (p_auto_ignore)
        else $error("on/off write taken under auto lighting");
    property p_deferred;
        !phase_tick |=> s.deb == $past(s.deb) &&
            s.edge_sel == $past(s.edge_sel);
    endproperty
    a_deferred: assert property (p_deferred)
        else $error("setting changed outside a phase start");
    property p_lvl_deferred;
        (s.pwr_done && !phase_tick) |=> s.intens == $past(s.intens);
    endproperty
    a_lvl_deferred: assert property (p_lvl_deferred)
        else $error("output level changed outside a phase start");
    property p_pull_none;
        (!is_in[0] || s.pull[1:0] == 2'h3)
            |=> !pull_up_en[0] && !pull_down_en[0];
    endproperty
    a_pull_none: assert property (p_pull_none)
        else $error("pull enabled for reserved code or non-input");
    property p_stat_mask;
        !is_in[4] |=> !s.stat[4];
    endproperty
    a_stat_mask: assert property (p_stat_mask)
        else $error("status set for a non-input pin");
    c_irq: cover property (|hit ##1 !irq_out_n);
    c_clear: cover property (!irq_out_n ##1 ctrl_rd ##2 irq_out_n);
    c_phase: cover property (host_req.wr ##[1:50] phase_tick);
endmodule
`default_nettype wire

// *** logic/gif_map.svh ***
// offsets, field positions, reset values and timing counts of the gpio unit
`ifndef GIF_MAP_SVH
`define GIF_MAP_SVH
`define GIF_OFS_PULL_HI 8'h68
`define GIF_OFS_PULL_LO 8'h69
`define GIF_OFS_EDGE_HI 8'h6a
`define GIF_OFS_EDGE_LO 8'h6b
`define GIF_OFS_DEBOUNCE 8'h6a
`define GIF_OFS_FADE_HI 8'h6a
`define GIF_OFS_FADE_LO 8'h6b
`define GIF_OFS_IRQ_SRC 8'h00
`define GIF_OFS_IN_STAT 8'h07
`define GIF_OFS_ONOFF 8'h0a
`define GIF_OFS_PIN_SEL 8'h0b
`define GIF_OFS_LEVEL 8'h0c
`define GIF_BANK_PULL_EDGE 2'h0
`define GIF_BANK_DEBOUNCE 2'h1
`define GIF_BANK_FADE 2'h2
`define GIF_BANK_CTRL 2'h3
`define GIF_IRQ_INPUT_BIT 4
`define GIF_PULL_RST 16'h0000
`define GIF_EDGE_RST 16'h0000
`define GIF_DEBOUNCE_RST 8'h00
`define GIF_FADE_RST 16'h2a50
`define GIF_DEB_SAMPLES 4'ha
`define GIF_CLK_HZ 20000000
`define GIF_DEB_PERIOD_US 1000
`define GIF_DEB_TICK_CYC ((`GIF_CLK_HZ / 1000000) * `GIF_DEB_PERIOD_US)
`define GIF_PHASE_PERIOD_US 1000
`define GIF_PHASE_CYC ((`GIF_CLK_HZ / 1000000) * `GIF_PHASE_PERIOD_US)
`endif

// *** logic/gif_pkg.sv ***
// types shared by the gpio unit
`default_nettype none
package gif_pkg;
    typedef enum logic [1:0] {
        GIF_EDGE_NONE, GIF_EDGE_RISE, GIF_EDGE_FALL, GIF_EDGE_BOTH
    } gif_edge_e;
    typedef enum logic [1:0] {
        GIF_FN_INPUT, GIF_FN_DIRECT, GIF_FN_FADE, GIF_FN_SPECIAL
    } gif_func_e;
    typedef enum logic [1:0] {
        GIF_FADE_SINGLE, GIF_FADE_CONT, GIF_FADE_REPEAT, GIF_FADE_RSVD
    } gif_fade_e;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gif_req_s;
    typedef struct packed {
        logic [7:0][1:0] func;
        logic [7:0] pwrup;
        logic [7:0] auto;
        logic [7:0][7:0] on_lvl;
        logic [7:0][7:0] off_lvl;
    } gif_pincfg_s;
    typedef struct packed {
        logic [23:0] cnt;
        logic tick;
    } gif_div_s;
    typedef struct packed {
        logic [2:0] sync;
        logic cand;
        logic [3:0] cnt;
        logic level;
    } gif_deb_s;
    typedef struct packed {
        logic [15:0] pend_pull;
        logic [15:0] pend_edge;
        logic [7:0] pend_deb;
        logic [15:0] pend_fade;
        logic [7:0] pend_onoff;
        logic [2:0] pend_sel;
        logic pend_lvl_we;
        logic [7:0] pend_lvl;
        logic [15:0] pull;
        logic [15:0] edge_sel;
        logic [7:0] deb;
        logic [15:0] fade;
        logic [7:0] onoff;
        logic [7:0][7:0] intens;
        logic [7:0] irq_src;
        logic [7:0] prev;
        logic [7:0] stat;
        logic irq_n;
        logic wake;
        logic pwr_done;
        logic [7:0] rdata;
        logic [7:0] pu;
        logic [7:0] pd;
        logic [15:0] fade_out;
    } gif_top_s;
endpackage
`default_nettype wire

// *** logic/gif_tick_div.sv ***
// divider giving a one-cycle enable pulse every CYCLES clocks
`default_nettype none
module gif_tick_div #(
    parameter int unsigned CYCLES = 20000
) (
    input wire logic clock,
    input wire logic reset_n,
    output logic tick
);
    import gif_pkg::*;
    gif_div_s s, next_s;
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.cnt == 24'(CYCLES - 1)) begin
            next_s.cnt = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 24'h1;
        end
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign tick = s.tick;
endmodule
`default_nettype wire

// *** logic/gif_debounce.sv ***
// one input pin: three-stage synchroniser and optional sample debounce
`include "gif_map.svh"
`default_nettype none
module gif_debounce (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic pin,
    input wire logic sample_tick,
    input wire logic enable,
    output logic level
);
    import gif_pkg::*;
    gif_deb_s s, next_s;
    always_comb begin
        next_s = s;
        next_s.sync = {s.sync[1:0], pin};
        if (!enable) begin
            next_s.cnt = '0;
            // second and third stage must agree
            if (s.sync[1] == s.sync[2]) begin
                next_s.level = s.sync[2];
            end
        end else if (sample_tick) begin
            if (s.sync[2] != s.cand) begin
                next_s.cand = s.sync[2];
                next_s.cnt = 4'h1;
            end else if (s.cnt != `GIF_DEB_SAMPLES) begin
                next_s.cnt = s.cnt + 4'h1;
                if (s.cnt + 4'h1 == `GIF_DEB_SAMPLES) begin
                    next_s.level = s.cand;
                end
            end
        end
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign level = s.level;

    property p_deb_ten;
        @(posedge clock) disable iff (!reset_n)
        ($past(enable) && $changed(s.level)) |-> s.cnt == `GIF_DEB_SAMPLES;
    endproperty
    a_deb_ten: assert property (p_deb_ten)
        else $error("debounced level changed before ten samples");
    c_deb_change: cover property (@(posedge clock) disable iff (!reset_n)
        enable && $changed(s.level));
endmodule
`default_nettype wire

// *** test/gif_switch_model.sv ***
// switch model driving the general input pins, with optional contact bounce
`default_nettype none
module gif_switch_model (
    input wire logic clock,
    input wire logic [7:0] target,
    input wire logic bounce,
    output logic [7:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] held = 8'h00;
    logic [7:0] chg = 8'h00;
    int left = 0;
    initial pins = 8'h00;
    // chatter first, so a debounce that trusts one sample gets caught
    always @(negedge clock) begin
        if (target !== held) begin
            chg = target ^ held;
            held = target;
            left = bounce ? 7 : 0;
        end
        if (left > 0) begin
            left--;
            pins <= left[0] ? held ^ chg : held;
        end else begin
            pins <= held;
        end
    end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// testbench for the gpio unit: registers, edges, debounce, levels
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import gif_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    gif_req_s host_req = '0;
    gif_pincfg_s cfg;
    logic [7:0] host_rdata, target, pins, pu, pd, onoff;
    logic bounce = 1'b0;
    logic lpm = 1'b0;
    logic irq_n, wake;
    logic wake_seen = 1'b0;
    logic [15:0] fade;
    logic [63:0] lvl;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    int model [int];
    logic [9:0] keys [7] = '{10'h068, 10'h069, 10'h06a, 10'h06b,
        10'h16a, 10'h26a, 10'h26b};
    int rst [7] = '{0, 0, 0, 0, 0, 'h2a, 'h50};

    always #25 clock = ~clock;

    gif_switch_model sw (.clock(clock), .target(target), .bounce(bounce),
        .pins(pins));

    gif_gpio #(.DEB_TICK_CYC(4), .PHASE_CYC(8)) DUT (.clock(clock),
        .reset_n(reset_n), .host_req(host_req), .host_rdata(host_rdata),
        .general_input_pin(pins), .pin_cfg(cfg), .low_power_mode(lpm),
        .irq_out_n(irq_n), .wake_request(wake), .pull_up_en(pu),
        .pull_down_en(pd), .fade_mode_out(fade),
        .fading_output_onoff(onoff), .direct_output_level(lvl));

    always @(posedge clock) begin
        if (wake) wake_seen <= 1'b1;
        cycles++;
        if (cycles == 6000) begin
            fails++;
            $display("[ERR] %0t timeout got %h exp %h", $time, cycles, 0);
            final_report();
        end
    end

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // one-cycle strobe, model tracks the pending copy
    task automatic wr(input logic [1:0] b, input logic [7:0] a,
            input logic [7:0] d);
        @(negedge clock);
        host_req = '{wr: 1'b1, rd: 1'b0, bank: b, addr: a, wdata: d};
        @(negedge clock);
        host_req.wr = 1'b0;
        if (model.exists({b, a})) model[{b, a}] = d;
    endtask

    task automatic rd(input logic [1:0] b, input logic [7:0] a,
            output logic [7:0] d);
        @(negedge clock);
        host_req = '{wr: 1'b0, rd: 1'b1, bank: b, addr: a, wdata: 8'h00};
        @(negedge clock);
        host_req.rd = 1'b0;
        d = host_rdata;
    endtask

    initial begin
        logic [7:0] d, r, eu, ed;
        int rise;
        int fall;
        void'($urandom(32'h93398b19));
        cfg.func = {2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
        // settings loaded once, fades from reset values
        // no pin in special mode, nothing owed there
        // fading pins keep the power-up bit clear
        cfg.pwrup = 8'h10;
        cfg.auto = 8'h40;
        cfg.on_lvl = {$urandom(), $urandom()};
        cfg.off_lvl = {$urandom(), $urandom()};
        target = 8'hf0;
        foreach (keys[i]) model[keys[i]] = rst[i];
        cyc(12);
        reset_n = 1'b1;
        cyc(3);
        foreach (keys[i]) begin
            rd(keys[i][9:8], keys[i][7:0], d);
            `CHK(d, 8'(model[keys[i]]));
        end
        `CHK(irq_n, 1'b1);
        `CHK(lvl[39:32], cfg.on_lvl[4]);
        `CHK(lvl[47:40], cfg.off_lvl[5]);
        `CHK(fade, 16'h2000);
        $display("test reset done");
        lpm = 1'b1;
        for (int c = 0; c < 4; c++) begin
            rise = c % 2;
            fall = c / 2;
            wr(2'h0, 8'h6b, 8'(c));
            cyc(16);
            wake_seen = 1'b0;
            target[0] = 1'b1;
            cyc(8);
            `CHK(irq_n, !rise[0]);
            `CHK(wake_seen, rise[0]);
            rd(2'h3, 8'h07, d);
            `CHK(d, 8'h01);
            rd(2'h3, 8'h00, d);
            `CHK(d, rise[0] ? 8'h10 : 8'h00);
            wake_seen = 1'b0;
            target[0] = 1'b0;
            cyc(8);
            `CHK(irq_n, !fall[0]);
            `CHK(wake_seen, fall[0]);
            rd(2'h3, 8'h00, d);
            `CHK(d, fall[0] ? 8'h10 : 8'h00);
        end
        lpm = 1'b0;
        $display("test edges done");
        repeat (4) begin
            r = 8'($urandom());
            wr(2'h0, 8'h69, r);
            wr(2'h0, 8'h68, ~r);
            cyc(16);
            eu = 8'h00;
            ed = 8'h00;
            for (int i = 0; i < 4; i++) begin
                eu[i] = (r[2 * i +: 2] == 2'b01);
                ed[i] = (r[2 * i +: 2] == 2'b10);
            end
            `CHK(pu, eu);
            `CHK(pd, ed);
            rd(2'h0, 8'h68, d);
            `CHK(d, ~r);
        end
        $display("test pulls done");
        // all fading outputs are still off here
        wr(2'h2, 8'h6a, 8'hf0);
        // one more edge so an early apply would already show
        cyc(1);
        `CHK(fade, 16'h2000);
        rd(2'h2, 8'h6a, d);
        `CHK(d, 8'hf0);
        cyc(16);
        `CHK(fade, 16'h0000);
        wr(2'h2, 8'h6a, 8'h60);
        cyc(16);
        `CHK(fade, 16'h6000);
        $display("test fade done");
        wr(2'h0, 8'h6b, 8'h0c);
        wr(2'h1, 8'h6a, 8'h02);
        cyc(16);
        bounce = 1'b1;
        target[1] = 1'b1;
        cyc(20);
        rd(2'h3, 8'h07, d);
        `CHK(d[1], 1'b0);
        cyc(60);
        rd(2'h3, 8'h07, d);
        `CHK(d[1], 1'b1);
        rd(2'h3, 8'h00, d);
        `CHK(d, 8'h10);
        $display("test debounce done");
        wr(2'h3, 8'h0a, 8'hff);
        cyc(16);
        `CHK(onoff[7:6], 2'b10);
        r = 8'($urandom());
        wr(2'h3, 8'h0b, 8'h04);
        wr(2'h3, 8'h0c, r);
        cyc(16);
        `CHK(lvl[39:32], r);
        wr(2'h3, 8'h0b, 8'h06);
        wr(2'h3, 8'h0c, ~r);
        cyc(16);
        `CHK(lvl[47:32], {cfg.off_lvl[5], r});
        rd(2'h3, 8'h05, d);
        `CHK(d, 8'h00);
        $display("test outputs done");
        final_report();
    end
endmodule
`default_nettype wire
